// ===== hw/hkio_map.svh
// register offsets, field positions, reset values and timing figures of the key and handwheel image
`ifndef HKIO_MAP_SVH
`define HKIO_MAP_SVH

`define HKIO_CLK_HZ 20000000
`define HKIO_US_PER_S 1000000
`define HKIO_KEY_DEB_US 5000
`define HKIO_ENC_DEB_US 20

`define HKIO_OFS_IMAGE0 4'h0
`define HKIO_OFS_IMAGE1 4'h4
`define HKIO_OFS_LAMP 4'h8
`define HKIO_OFS_STATUS 4'hC

`define HKIO_KEY_COUNT 14
`define HKIO_LAMP_COUNT 8
`define HKIO_FILT_KEY_W 17
`define HKIO_FILT_ENC_W 2

`define HKIO_LAMP_RST 8'h00
`define HKIO_CNT_RST 8'h00
`define HKIO_KEYS_RST 14'h0000
`define HKIO_CNT_ONE 8'h01

`define HKIO_SW_MIDDLE 2'h0
`define HKIO_SW_CCW 2'h1
`define HKIO_SW_CW 2'h2
`define HKIO_SW_BOTH 2'h3

`define HKIO_STAT_A_BIT 0
`define HKIO_STAT_B_BIT 1
`define HKIO_LAMP_LANE 0

`endif

// ===== hw/hkio_pkg.sv
// types shared by the key and handwheel image logic
package hkio_pkg;

  typedef enum logic [0:0] {
    HKIO_BUS_IDLE = 1'b0,
    HKIO_BUS_ACK = 1'b1
  } hkio_bus_state_t;

  // five image bytes: keys 1-8, keys 9-14, switch and pushbutton, forward count; backward count in second word
  typedef struct packed {
    logic [7:0] fwd_count;
    logic [4:0] rsvd_b2;
    logic pushbutton;
    logic [1:0] key_switch;
    logic [1:0] rsvd_b1;
    logic [5:0] keys_hi;
    logic [7:0] keys_lo;
  } hkio_image0_t;

endpackage : hkio_pkg

// ===== hw/hkio_filt_if.sv
// raw and filtered input levels passed between the image top and its input filter
interface hkio_filt_if #(
  parameter int W = 1
);
  logic [W-1:0] raw;
  logic [W-1:0] clean;

  modport filter (
    input raw,
    output clean
  );

  modport user (
    output raw,
    input clean
  );
endinterface : hkio_filt_if

// ===== hw/hkio_debounce.sv
// two-stage synchroniser and per-bit debounce filter
module hkio_debounce #(
  parameter int W = 1,
  parameter int COUNT = 4
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  hkio_filt_if.filter bus
);
  localparam int CW = $clog2(COUNT + 1);

  logic [W-1:0] sync1_q;
  logic [W-1:0] sync2_q;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (i_clk_en) begin
      sync1_q <= bus.raw;
      sync2_q <= sync1_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic stable_q;
      logic stable_d;
      logic [CW-1:0] cnt_q;
      logic [CW-1:0] cnt_d;

      // a level must hold for COUNT cycles before it is taken
      always_comb begin
        stable_d = stable_q;
        cnt_d = '0;
        if (sync2_q[g] != stable_q) begin
          if (cnt_q == CW'(COUNT - 1)) begin
            stable_d = sync2_q[g];
          end else begin
            cnt_d = cnt_q + CW'(1);
          end
        end
      end

      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          stable_q <= 1'b0;
          cnt_q <= '0;
        end else if (i_clk_en) begin
          stable_q <= stable_d;
          cnt_q <= cnt_d;
        end
      end

      assign bus.clean[g] = stable_q;
    end
  endgenerate
endmodule : hkio_debounce

// ===== hw/hkio_top.sv
// operator panel key, lamp and handwheel image with an avalon-mm register slave
// What this block does
// [R1] each of fourteen function keys reads 1 while held, 0 when released
// [R2] first eight keys have lamps lit when their lamp bit is 1
// [R3] key switch reads 00 middle, 01 counterclockwise, 10 clockwise
// [R4] illuminated pushbutton reads 1 while pressed, 0 when released
// [R5] both handwheel counters are zero after startup
// [R6] each pulse increments exactly one counter chosen by direction, never decrements
// [R7] counters are eight bits and wrap from 255 to 0 silently
// [R8] counters read as unsigned bytes, bit 0 least significant
// [R9] one handwheel revolution gives fifty counted pulses
// [R10] every pulse up to two hundred per second is counted
// [R11] plc reads both counters at least once a second
// [R12] plc should scan counters at 100 ms or faster
// [R13] plc takes forward change minus backward change, modulo 256; the bench model keeps a 9-bit difference, modulo 512
// [R14] no absolute position or setpoint is kept, only relative counts
// [R15] keys, switch and counters fill a five-byte input image
// [R16] encoder inputs are synchronised and counted once per clean step
// [R17] keys, pushbutton and switch are synchronised and debounced
//
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`include "hkio_map.svh"

module hkio_top #(
  parameter int KEY_DEB_CYC = `HKIO_KEY_DEB_US * (`HKIO_CLK_HZ / `HKIO_US_PER_S),
  parameter int ENC_DEB_CYC = `HKIO_ENC_DEB_US * (`HKIO_CLK_HZ / `HKIO_US_PER_S)
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [`HKIO_KEY_COUNT-1:0] i_function_key_bits,
  input wire logic i_pushbutton,
  input wire logic i_key_switch_ccw,
  input wire logic i_key_switch_cw,
  input wire logic i_wheel_a,
  input wire logic i_wheel_b,
  output logic [`HKIO_LAMP_COUNT-1:0] o_function_key_lamp_bits
);

  function automatic logic hkio_sel(input logic [3:0] addr, input logic [3:0] ofs);
    hkio_sel = (addr == ofs);
  endfunction : hkio_sel

  // input filtering
  hkio_filt_if #(.W(`HKIO_FILT_KEY_W)) key_if ();
  hkio_filt_if #(.W(`HKIO_FILT_ENC_W)) enc_if ();

  assign key_if.raw = {i_key_switch_cw, i_key_switch_ccw, i_pushbutton, i_function_key_bits};
  assign enc_if.raw = {i_wheel_b, i_wheel_a};

  hkio_debounce #(
    .W(`HKIO_FILT_KEY_W),
    .COUNT(KEY_DEB_CYC)
  ) u_key_filt ( // [R17]
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .bus(key_if.filter)
  );

  hkio_debounce #(
    .W(`HKIO_FILT_ENC_W),
    .COUNT(ENC_DEB_CYC)
  ) u_enc_filt ( // [R16]
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .bus(enc_if.filter)
  );

  logic [`HKIO_KEY_COUNT-1:0] clean_keys;
  logic clean_push;
  logic clean_ccw;
  logic clean_cw;
  logic clean_a;
  logic clean_b;

  assign {clean_cw, clean_ccw, clean_push, clean_keys} = key_if.clean;
  assign {clean_b, clean_a} = enc_if.clean;

  // key image
  logic [`HKIO_KEY_COUNT-1:0] keys_q;
  logic [`HKIO_KEY_COUNT-1:0] keys_d;
  logic push_q;
  logic push_d;
  logic [1:0] sw_q;
  logic [1:0] sw_d;

  always_comb begin
    keys_d = clean_keys; // [R1]
    push_d = clean_push; // [R4]
    // both contacts closed only in transit: keep the last valid position
    sw_d = sw_q;
    if (clean_ccw && !clean_cw) begin
      sw_d = `HKIO_SW_CCW; // [R3]
    end else if (clean_cw && !clean_ccw) begin
      sw_d = `HKIO_SW_CW; // [R3]
    end else if (!clean_cw && !clean_ccw) begin
      sw_d = `HKIO_SW_MIDDLE; // [R3]
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      keys_q <= `HKIO_KEYS_RST;
      push_q <= 1'b0;
      sw_q <= `HKIO_SW_MIDDLE;
    end else if (i_clk_en) begin
      keys_q <= keys_d;
      push_q <= push_d;
      sw_q <= sw_d;
    end
  end

  // handwheel pulse counters
  logic a_prev_q;
  logic a_prev_d;
  logic [7:0] fwd_q;
  logic [7:0] fwd_d;
  logic [7:0] bwd_q;
  logic [7:0] bwd_d;
  logic step;
  logic fwd_step;
  logic bwd_step;

  // one count per rising edge of the filtered a track; b level gives direction
  assign step = clean_a && !a_prev_q; // [R16] [R9]
  assign fwd_step = step && !clean_b;
  assign bwd_step = step && clean_b;

  always_comb begin
    a_prev_d = clean_a;
    fwd_d = fwd_q;
    bwd_d = bwd_q;
    if (fwd_step) begin
      fwd_d = fwd_q + `HKIO_CNT_ONE; // [R6] [R7] [R10]
    end else if (bwd_step) begin
      bwd_d = bwd_q + `HKIO_CNT_ONE; // [R6] [R7] [R10]
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      a_prev_q <= 1'b0;
      fwd_q <= `HKIO_CNT_RST; // [R5]
      bwd_q <= `HKIO_CNT_RST; // [R5]
    end else if (i_clk_en) begin
      a_prev_q <= a_prev_d;
      fwd_q <= fwd_d;
      bwd_q <= bwd_d;
    end
  end

  // image assembly
  hkio_pkg::hkio_image0_t image0;

  always_comb begin
    image0 = '0;
    image0.keys_lo = keys_q[`HKIO_LAMP_COUNT-1:0]; // [R15]
    image0.keys_hi = keys_q[`HKIO_KEY_COUNT-1:`HKIO_LAMP_COUNT]; // [R15]
    image0.key_switch = sw_q;
    image0.pushbutton = push_q;
    image0.fwd_count = fwd_q; // [R8] [R14]
  end

  // avalon-mm slave
  hkio_pkg::hkio_bus_state_t state_q;
  hkio_pkg::hkio_bus_state_t state_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [`HKIO_LAMP_COUNT-1:0] lamp_q;
  logic [`HKIO_LAMP_COUNT-1:0] lamp_d;
  logic req;
  logic ack;

  assign req = i_avs_read || i_avs_write;
  assign ack = (state_q == hkio_pkg::HKIO_BUS_ACK) && i_clk_en;
  assign o_avs_waitrequest = req && !ack;
  assign o_avs_readdata = rdata_q;
  assign o_function_key_lamp_bits = lamp_q; // [R2]

  always_comb begin
    state_d = state_q;
    rdata_d = rdata_q;
    lamp_d = lamp_q;
    case (state_q)
      hkio_pkg::HKIO_BUS_IDLE: begin
        if (req) begin
          state_d = hkio_pkg::HKIO_BUS_ACK;
          rdata_d = '0;
          if (i_avs_read) begin
            if (hkio_sel(i_avs_address, `HKIO_OFS_IMAGE0)) begin
              rdata_d = image0;
            end else if (hkio_sel(i_avs_address, `HKIO_OFS_IMAGE1)) begin
              rdata_d[7:0] = bwd_q; // [R8] [R15]
            end else if (hkio_sel(i_avs_address, `HKIO_OFS_LAMP)) begin
              rdata_d[`HKIO_LAMP_COUNT-1:0] = lamp_q;
            end else if (hkio_sel(i_avs_address, `HKIO_OFS_STATUS)) begin
              rdata_d[`HKIO_STAT_A_BIT] = clean_a;
              rdata_d[`HKIO_STAT_B_BIT] = clean_b;
            end
          end
        end
      end
      hkio_pkg::HKIO_BUS_ACK: begin
        state_d = hkio_pkg::HKIO_BUS_IDLE;
        if (i_avs_write && hkio_sel(i_avs_address, `HKIO_OFS_LAMP) && i_avs_byteenable[`HKIO_LAMP_LANE]) begin
          lamp_d = i_avs_writedata[`HKIO_LAMP_COUNT-1:0]; // [R2]
        end
      end
      default: begin
        state_d = hkio_pkg::HKIO_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= hkio_pkg::HKIO_BUS_IDLE;
      rdata_q <= '0;
      lamp_q <= `HKIO_LAMP_RST;
    end else if (i_clk_en) begin
      state_q <= state_d;
      rdata_q <= rdata_d;
      lamp_q <= lamp_d;
    end
  end

  // checks
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  logic started_q;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      started_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
    end
  end

  sequence s_fwd_pulse;
    fwd_step && i_clk_en;
  endsequence

  sequence s_bwd_pulse;
    bwd_step && i_clk_en;
  endsequence

  sequence s_lamp_write;
    i_avs_write && !o_avs_waitrequest && hkio_sel(i_avs_address, `HKIO_OFS_LAMP) && i_avs_byteenable[`HKIO_LAMP_LANE];
  endsequence

  a_fwd_count_step: assert property ( // [R6] [R7]
    s_fwd_pulse |=> (fwd_q == $past(fwd_q) + `HKIO_CNT_ONE) && (bwd_q == $past(bwd_q))
  ) else $error("forward pulse not counted once");

  a_bwd_count_step: assert property ( // [R6] [R7]
    s_bwd_pulse |=> (bwd_q == $past(bwd_q) + `HKIO_CNT_ONE) && (fwd_q == $past(fwd_q))
  ) else $error("backward pulse not counted once");

  a_counts_still: assert property ( // [R14] [R6]
    !(step && i_clk_en) |=> $stable(fwd_q) && $stable(bwd_q)
  ) else $error("counter moved without a pulse");

  a_counts_reset: assert property ( // [R5]
    !started_q |-> (fwd_q == `HKIO_CNT_RST) && (bwd_q == `HKIO_CNT_RST)
  ) else $error("counters not cleared after startup");

  a_lamp_write: assert property ( // [R2]
    s_lamp_write |=> o_function_key_lamp_bits == $past(i_avs_writedata[`HKIO_LAMP_COUNT-1:0])
  ) else $error("lamp bits do not follow the write");

  a_switch_code: assert property ( // [R3]
    (clean_ccw && !clean_cw && i_clk_en) |=> sw_q == `HKIO_SW_CCW
  ) else $error("key switch code wrong");

  a_switch_legal: assert property ( // [R3]
    sw_q != `HKIO_SW_BOTH
  ) else $error("key switch shows an illegal code");

  a_key_image: assert property ( // [R1] [R4]
    i_clk_en |=> (keys_q == $past(clean_keys)) && (push_q == $past(clean_push))
  ) else $error("key image does not track filtered keys");

  a_read_answer: assert property ( // [R15] [R8]
    (i_avs_read && i_clk_en && state_q == hkio_pkg::HKIO_BUS_IDLE && hkio_sel(i_avs_address, `HKIO_OFS_IMAGE1))
      |=> (o_avs_readdata == {24'h000000, $past(bwd_q)})
  ) else $error("backward count read wrong");

  a_wait_bounded: assert property ( // [R15]
    (req && i_clk_en && state_q == hkio_pkg::HKIO_BUS_IDLE) ##1 i_clk_en |-> !o_avs_waitrequest
  ) else $error("waitrequest held too long");

endmodule : hkio_top

// ===== verification/hkio_plc_model.sv
// plc-side model: polls the panel image over avalon-mm and derives net handwheel rotation
module hkio_plc_model (
  input wire logic i_clock,
  input wire logic [31:0] i_avs_readdata,
  input wire logic i_avs_waitrequest,
  output logic [3:0] o_avs_address,
  output logic o_avs_read,
  output logic o_avs_write,
  output logic [31:0] o_avs_writedata,
  output logic [3:0] o_avs_byteenable
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] prev_f = 8'h00;
  logic [7:0] prev_b = 8'h00;
  logic timed_out = 1'b0;

  initial begin
    o_avs_address = 4'h0;
    o_avs_read = 1'b0;
    o_avs_write = 1'b0;
    o_avs_writedata = 32'h0;
    o_avs_byteenable = 4'h0;
  end

  // request held until waitrequest is seen low, data taken at that same edge
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clock);
    o_avs_address <= a;
    o_avs_writedata <= d;
    o_avs_byteenable <= be;
    o_avs_read <= !wr;
    o_avs_write <= wr;
    do begin
      @(posedge i_clock);
      n++;
    end while (i_avs_waitrequest !== 1'b0 && n < 100);
    if (i_avs_waitrequest !== 1'b0) begin
      timed_out = 1'b1;
    end
    q = i_avs_readdata;
    o_avs_read <= 1'b0;
    o_avs_write <= 1'b0;
  endtask : xfer

  // one scan of both counters; the bench calls it far more often than once a second
  task automatic poll(output logic [7:0] f, output logic [7:0] b, output logic [8:0] net);
    logic [31:0] q;
    xfer(1'b0, 4'h0, 32'h0, 4'hF, q);
    f = q[31:24];
    xfer(1'b0, 4'h4, 32'h0, 4'hF, q);
    b = q[7:0];
    net = {1'b0, 8'(f - prev_f)} - {1'b0, 8'(b - prev_b)};
    prev_f = f;
    prev_b = b;
  endtask : poll
endmodule : hkio_plc_model

// ===== verification/tb_hkio_top.sv
// self-checking bench for the key, lamp and handwheel image
module tb_hkio_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [13:0] keys = 14'h0000;
  logic pb = 1'b0;
  logic ccw = 1'b0;
  logic cw = 1'b0;
  logic wa = 1'b0;
  logic wb = 1'b0;
  logic [31:0] rdata;
  logic wait_req;
  logic [3:0] addr;
  logic rd;
  logic wr;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [7:0] lamps;
  logic [31:0] q;
  logic [7:0] f;
  logic [7:0] b;
  logic [8:0] net;
  int fail_count = 0;
  int n_tests = 0;

  always #25 clk = ~clk;

  hkio_top #(.KEY_DEB_CYC(4), .ENC_DEB_CYC(3)) i_dut (
    .i_clock(clk), .i_rst_n(rst_n), .i_clk_en(ce),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
    .i_function_key_bits(keys), .i_pushbutton(pb), .i_key_switch_ccw(ccw), .i_key_switch_cw(cw),
    .i_wheel_a(wa), .i_wheel_b(wb), .o_function_key_lamp_bits(lamps)
  );

  hkio_plc_model i_plc (
    .i_clock(clk), .i_avs_readdata(rdata), .i_avs_waitrequest(wait_req),
    .o_avs_address(addr), .o_avs_read(rd), .o_avs_write(wr), .o_avs_writedata(wdata),
    .o_avs_byteenable(be)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  // a bus wait that ran out ends the run as a failure
  initial begin
    wait (i_plc.timed_out === 1'b1);
    fail_count++;
    results();
  end

  // direction level set well before the counting edge of track a
  task automatic pulse(input logic bwd, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk) wb <= bwd;
      repeat (8) @(posedge clk);
      wa <= 1'b1;
      repeat (8) @(posedge clk);
      wa <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask : pulse

  task automatic panel(input logic [13:0] k, input logic p, input logic c, input logic w);
    @(posedge clk);
    keys <= k;
    pb <= p;
    ccw <= c;
    cw <= w;
    repeat (12) @(posedge clk);
  endtask : panel

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    i_plc.poll(f, b, net);
    check({24'h0, f}, 32'h0);
    check({24'h0, b}, 32'h0);
    i_plc.xfer(1'b0, 4'h8, 32'h0, 4'hF, q);
    check(q, 32'h0);
    $display("test startup done");

    panel(14'h2A55, 1'b1, 1'b1, 1'b0);
    i_plc.xfer(1'b0, 4'h0, 32'h0, 4'hF, q);
    check(q, 32'h0005_2A55);
    panel(14'h15AA, 1'b0, 1'b0, 1'b1);
    i_plc.xfer(1'b0, 4'h0, 32'h0, 4'hF, q);
    check(q, 32'h0002_15AA);
    // both contacts closed in transit: the last position stays
    panel(14'h15AA, 1'b0, 1'b1, 1'b1);
    i_plc.xfer(1'b0, 4'h0, 32'h0, 4'hF, q);
    check(q, 32'h0002_15AA);
    panel(14'h0000, 1'b0, 1'b0, 1'b0);
    i_plc.xfer(1'b0, 4'h0, 32'h0, 4'hF, q);
    check(q, 32'h0);
    // a one-cycle key blip is bounce and must not reach the image
    @(posedge clk) keys <= 14'h0001;
    @(posedge clk) keys <= 14'h0000;
    repeat (12) @(posedge clk);
    i_plc.xfer(1'b0, 4'h0, 32'h0, 4'hF, q);
    check(q, 32'h0);
    $display("test keys done");

    i_plc.xfer(1'b1, 4'h8, 32'h0000_00A5, 4'h1, q);
    @(negedge clk);
    check({24'h0, lamps}, 32'hA5);
    i_plc.xfer(1'b1, 4'h8, 32'h0000_005A, 4'h0, q);
    i_plc.xfer(1'b0, 4'h8, 32'h0, 4'hF, q);
    check(q, 32'hA5);
    check({24'h0, lamps}, 32'hA5);
    $display("test lamps done");

    pulse(1'b0, 50);
    i_plc.poll(f, b, net);
    check({24'h0, f}, 32'h32);
    check({24'h0, b}, 32'h0);
    check({23'h0, net}, 32'h32);
    pulse(1'b1, 11);
    i_plc.poll(f, b, net);
    check({24'h0, b}, 32'h0B);
    check({23'h0, net}, 32'h1F5);
    // a one-cycle blip on track a is bounce and must not count
    @(posedge clk) wa <= 1'b1;
    @(posedge clk) wa <= 1'b0;
    repeat (12) @(posedge clk);
    i_plc.poll(f, b, net);
    check({23'h0, net}, 32'h0);
    // filtered tracks: a low, b still high from the backward pulses
    i_plc.xfer(1'b0, 4'hC, 32'h0, 4'hF, q);
    check(q, 32'h2);
    pulse(1'b0, 206);
    i_plc.poll(f, b, net);
    check({24'h0, f}, 32'h0);
    check({23'h0, net}, 32'hCE);
    // with the clock enable low the panel is frozen and sees no pulse
    @(posedge clk) ce <= 1'b0;
    pulse(1'b0, 2);
    @(posedge clk) ce <= 1'b1;
    i_plc.poll(f, b, net);
    check({23'h0, net}, 32'h0);
    $display("test handwheel done");

    @(posedge clk) rst_n <= 1'b0;
    @(posedge clk) rst_n <= 1'b1;
    i_plc.poll(f, b, net);
    check({24'h0, f}, 32'h0);
    check({24'h0, b}, 32'h0);
    check({24'h0, lamps}, 32'h0);
    $display("test restart done");
    results();
  end
endmodule : tb_hkio_top
